// ---- verilog/lin_xcvr_dev.sv ----
// LIN transceiver control, device end: serial slave, transmit/receive
// paths, fail-safes and sleep wake-up detection.
// Assumes the link pins and analog comparators are asynchronous to core_clk,
// and the operating-state inputs come from logic on core_clk.
//
// Notes on behaviour
// - Supply undervoltage forces bus recessive until gone.
// - Interface works only in Normal state.
// - Host selects 20k, 10k or fast rate.
// - Overtemperature disables transmitter, receiver, high-side.
// - Transmit low drives bus low, high releases.
// - Floating transmit input reads recessive.
// - Long dominant input forces recessive, sets flag.
// - Receive output follows bus level.
// - Modes are transmit-receive and disabled.
// - Transmit-receive select ignored while transmit low.
// - Sleep disables transmit, weak pull-up, watches bus.
// - Wake needs fall, long dominant, rise.
// - Wake notifies, interrupts or restarts supply.
// - Wake detection enabled or disabled by host.
// - Frames are 16 bits, fixed field layout.
// - Bit 8 parity on writes, one on reads; a write's bit 8 comes from wdata, unchecked.
// - Reply carries status high, payload low.
// - No daisy-chain pass-through.
// - Op codes: readback, write, flags, reserved.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
module lin_xcvr_dev #(
  parameter int TXDOM_LIMIT = lin_pkg::TXDOM_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  lin_link_if.device      link,
  input  wire logic       bus_level,
  input  wire logic       supply_uv,
  input  wire logic       over_temp,
  input  wire logic       normal_state,
  input  wire logic       low_power_supply_on,
  input  wire logic       low_power_supply_off,
  output logic            bus_drive_low,
  output logic            weak_pullup_en,
  output logic [1:0]      rate_sel,
  output logic            hs_off,
  output logic            wake_event,
  output logic            wake_irq,
  output logic            supply_restart
);

  typedef enum logic [1:0] {WK_IDLE, WK_LOW, WK_LONG} wake_state_t;

  // ==========================================================
  // Input synchronisers
  logic [6:0] async_w;
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [6:0] prev_q;

  assign async_w = {link.sclk, link.cs_n, link.mosi, link.txd_l, bus_level, supply_uv, over_temp};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q   <= 7'h2F;
      s2_q   <= 7'h2F;
      prev_q <= 7'h2F;
    end else begin
      s1_q   <= async_w;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  logic sclk_s, cs_s, mosi_s, txd_s, bus_s, uv_s, ot_s;
  assign {sclk_s, cs_s, mosi_s, txd_s, bus_s, uv_s, ot_s} = s2_q;

  logic sclk_rise, sclk_fall, cs_fall, cs_rise, bus_fall, bus_rise;
  assign sclk_rise = sclk_s & ~prev_q[6];
  assign sclk_fall = ~sclk_s & prev_q[6];
  assign cs_fall   = ~cs_s & prev_q[5];
  assign cs_rise   = cs_s & ~prev_q[5];
  assign bus_rise  = bus_s & ~prev_q[2];
  assign bus_fall  = ~bus_s & prev_q[2];

  // ==========================================================
  // Control state
  logic [7:0] lin_reg_q;
  logic       txdom_flag_q;
  logic       wake_flag_q;
  logic       dom_to_q;
  logic       active_w;
  logic [7:0] status_w;
  logic [7:0] flags_w;

  assign active_w = normal_state & lin_reg_q[lin_pkg::F_TRX] & ~lin_reg_q[lin_pkg::F_SLEEP];
  assign status_w = {active_w, lin_reg_q[lin_pkg::F_TRX], lin_reg_q[lin_pkg::F_SLEEP],
                     uv_s, ot_s, txdom_flag_q, wake_flag_q, 1'b0};
  assign flags_w  = {4'h0, txdom_flag_q, uv_s, ot_s, wake_flag_q};

  // ==========================================================
  // Serial slave
  logic [15:0] rx_sr_q;
  logic [15:0] tx_sr_q;
  logic [15:0] rx_nx;
  logic [4:0]  bit_cnt_q;
  logic [7:0]  reply_w;
  logic        miso_q;
  logic        frame_done;
  logic [1:0]  op_w;
  logic [4:0]  addr_w;

  assign rx_nx = {rx_sr_q[14:0], mosi_s};

  // Payload chosen once op and address have arrived
  always_comb begin
    reply_w = 8'h00;
    if (rx_nx[7:6] == lin_pkg::OP_READBACK && rx_nx[5:1] == lin_pkg::LIN_REG_ADDR) begin
      reply_w = lin_reg_q;
    end else if (rx_nx[7:6] == lin_pkg::OP_FLAGS && rx_nx[5:1] == lin_pkg::LIN_REG_ADDR) begin
      reply_w = flags_w;
    end else if (rx_nx[7:6] == lin_pkg::OP_WRITE) begin
      reply_w = flags_w;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_sr_q   <= 16'h0000;
      tx_sr_q   <= 16'h0000;
      bit_cnt_q <= 5'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 5'h00;
      tx_sr_q   <= {status_w, flags_w};
    end else if (!cs_s) begin
      if (sclk_rise) begin
        rx_sr_q <= rx_nx;
        if (bit_cnt_q != 5'h1F) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
        if (bit_cnt_q == 5'h07) begin
          tx_sr_q[14:7] <= reply_w;
        end
      end else if (sclk_fall) begin
        tx_sr_q <= {tx_sr_q[14:0], 1'b0};
      end
    end
  end

  // Bits beyond the sixteenth are not forwarded anywhere
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= cs_s ? 1'b0 : tx_sr_q[15];
    end
  end

  // Only exact 16-bit frames act
  assign frame_done = cs_rise && bit_cnt_q == 5'(lin_pkg::FRAME_BITS);
  assign op_w       = rx_sr_q[lin_pkg::OP_HI:lin_pkg::OP_LO];
  assign addr_w     = rx_sr_q[lin_pkg::ADDR_HI:lin_pkg::ADDR_LO];

  // Parity bit is carried but not checked; reserved op does nothing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lin_reg_q <= lin_pkg::LIN_REG_RESET;
    end else if (frame_done && op_w == lin_pkg::OP_WRITE && addr_w == lin_pkg::LIN_REG_ADDR) begin
      if (!rx_sr_q[lin_pkg::F_TRX] || txd_s) begin
        lin_reg_q <= rx_sr_q[7:0];
      end
    end
  end

  logic flag_read;
  assign flag_read = frame_done && op_w == lin_pkg::OP_FLAGS && addr_w == lin_pkg::LIN_REG_ADDR;

  // ==========================================================
  // Transmit path and dominant timeout
  logic [23:0] dom_cnt_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dom_cnt_q <= 24'h000000;
      dom_to_q  <= 1'b0;
    end else if (!active_w || txd_s) begin
      dom_cnt_q <= 24'h000000;
      dom_to_q  <= 1'b0;
    end else if (dom_cnt_q == 24'(TXDOM_LIMIT - 1)) begin
      dom_to_q  <= 1'b1;
    end else begin
      dom_cnt_q <= dom_cnt_q + 24'h000001;
    end
  end

  // Set wins over the read-clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txdom_flag_q <= 1'b0;
    end else if (dom_to_q) begin
      txdom_flag_q <= 1'b1;
    end else if (flag_read) begin
      txdom_flag_q <= 1'b0;
    end
  end

  logic drive_q;
  logic rxd_q;
  logic weak_q;
  logic [1:0] rate_q;
  logic hs_off_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drive_q  <= 1'b0;
      rxd_q    <= 1'b1;
      weak_q   <= 1'b0;
      rate_q   <= lin_pkg::RATE_20K;
      hs_off_q <= 1'b0;
    end else begin
      drive_q  <= active_w & ~uv_s & ~ot_s & ~dom_to_q & ~txd_s;
      rxd_q    <= (active_w & ~ot_s) ? bus_s : 1'b1;
      weak_q   <= lin_reg_q[lin_pkg::F_SLEEP];
      rate_q   <= lin_reg_q[lin_pkg::F_RATE_HI:lin_pkg::F_RATE_LO];
      hs_off_q <= ot_s;
    end
  end

  // ==========================================================
  // Wake-up detection
  wake_state_t wk_q;
  logic [15:0] wk_cnt_q;
  logic        wake_q;
  logic        wake_irq_q;
  logic        restart_q;
  logic        wake_armed;
  logic        wake_flag_pulse_q;

  assign wake_armed = lin_reg_q[lin_pkg::F_SLEEP] & lin_reg_q[lin_pkg::F_WAKE_EN];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wk_q     <= WK_IDLE;
      wk_cnt_q <= 16'h0000;
      wake_q   <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      if (!wake_armed) begin
        wk_q <= WK_IDLE;
      end else begin
        case (wk_q)
          WK_IDLE: begin
            wk_cnt_q <= 16'h0000;
            if (bus_fall) begin
              wk_q <= WK_LOW;
            end
          end
          WK_LOW: begin
            wk_cnt_q <= wk_cnt_q + 16'h0001;
            if (bus_s) begin
              wk_q <= WK_IDLE;
            end else if (wk_cnt_q == 16'(lin_pkg::WAKE_MIN_CYCLES)) begin
              wk_q <= WK_LONG;
            end
          end
          WK_LONG: begin
            if (bus_rise) begin
              wake_q <= 1'b1;
              wk_q   <= WK_IDLE;
            end
          end
          default: wk_q <= WK_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_irq_q  <= 1'b0;
      restart_q   <= 1'b0;
      wake_flag_q <= 1'b0;
    end else begin
      wake_irq_q <= wake_q & low_power_supply_on;
      restart_q  <= wake_q & low_power_supply_off;
      if (wake_q) begin
        wake_flag_q <= 1'b1;
      end else if (flag_read) begin
        wake_flag_q <= 1'b0;
      end
    end
  end

  assign link.miso      = miso_q;
  assign link.rxd       = rxd_q;
  assign bus_drive_low  = drive_q;
  assign weak_pullup_en = weak_q;
  assign rate_sel       = rate_q;
  assign hs_off         = hs_off_q;
  assign wake_event     = wake_flag_pulse_q;
  assign wake_irq       = wake_irq_q;
  assign supply_restart = restart_q;

  // Notification to the state machine, one cycle after detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_flag_pulse_q <= 1'b0;
    end else begin
      wake_flag_pulse_q <= wake_q;
    end
  end

endmodule : lin_xcvr_dev

// ---- include/lin_pkg.sv ----
// Shared constants for the LIN transceiver control link: frame layout,
// control register fields, timing counts and the host's AXI4-Lite map.
// Assumes a single 50 MHz core clock on both ends.
package lin_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int WAKE_MIN_NS     = 70000;
  localparam int WAKE_MIN_CYCLES = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TXDOM_NS        = 6000000;
  localparam int TXDOM_CYCLES    = TXDOM_NS / CLK_PERIOD_NS;
  localparam int SCLK_HALF       = 25;

  // ==========================================================
  // Serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int OP_HI      = 15;
  localparam int OP_LO      = 14;
  localparam int ADDR_HI    = 13;
  localparam int ADDR_LO    = 9;
  localparam int PN_BIT     = 8;

  localparam logic [1:0] OP_READBACK = 2'h0;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_RSVD     = 2'h2;
  localparam logic [1:0] OP_FLAGS    = 2'h3;

  // ==========================================================
  // LIN control register
  localparam logic [4:0] LIN_REG_ADDR  = 5'h13;
  localparam logic [7:0] LIN_REG_RESET = 8'h00;
  localparam int F_TRX     = 7;
  localparam int F_SLEEP   = 6;
  localparam int F_RATE_HI = 5;
  localparam int F_RATE_LO = 4;
  localparam int F_WAKE_EN = 3;

  localparam logic [1:0] RATE_20K  = 2'h0;
  localparam logic [1:0] RATE_10K  = 2'h1;
  localparam logic [1:0] RATE_FAST = 2'h2;

  // ==========================================================
  // Host AXI4-Lite map
  localparam logic [7:0] HOST_CMD    = 8'h00;
  localparam logic [7:0] HOST_RESP   = 8'h04;
  localparam logic [7:0] HOST_TXCTL  = 8'h08;
  localparam logic [7:0] HOST_RXSTAT = 8'h0C;
  localparam int HOST_BUSY_BIT = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : lin_pkg

// ---- include/lin_link_if.sv ----
// Pins between the host microcontroller and the LIN transceiver control:
// serial port, transmit input and receive output.
// The transmit input has a pull-up: undriven it reads recessive.
interface lin_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic txd;
  logic txd_oe;
  logic txd_l;
  logic rxd;

  // Pull-up on the transmit input
  assign txd_l = txd_oe ? txd : 1'b1;

  modport device (input sclk, input cs_n, input mosi, output miso, input txd_l, output rxd);
  modport host   (output sclk, output cs_n, output mosi, input miso, output txd,
                  output txd_oe, input rxd);
endinterface : lin_link_if

// ---- verilog/lin_host_ctrl.sv ----
// LIN host end: AXI4-Lite register slave that sends 16-bit serial frames
// to the transceiver control and drives its transmit input.
// Assumes the link pins are asynchronous to core_clk.
module lin_host_ctrl (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  lin_link_if.host         link
);

  typedef enum logic [2:0] {SP_IDLE, SP_LEAD, SP_RUN, SP_LAG, SP_GAP} spi_state_t;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
    end else begin
      s1_q <= {link.miso, link.rxd};
      s2_q <= s1_q;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  logic        aw_have_q, w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic        start_w;
  logic        busy_w;
  logic [15:0] resp_q;
  logic [1:0]  txctl_q;
  spi_state_t  st_q;

  assign busy_w   = st_q != SP_IDLE;
  assign do_write = aw_have_q & w_have_q & ~bvalid;
  assign start_w  = do_write && awaddr_q == lin_pkg::HOST_CMD && !busy_w && wstrb_q[1:0] == 2'h3;
  assign awready  = ~aw_have_q;
  assign wready   = ~w_have_q;
  assign arready  = ~rvalid;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= lin_pkg::RESP_OKAY;
      txctl_q   <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= lin_pkg::RESP_OKAY;
        if (awaddr_q == lin_pkg::HOST_TXCTL) begin
          if (wstrb_q[0]) begin
            txctl_q <= wdata_q[1:0];
          end
        end else if (awaddr_q == lin_pkg::HOST_CMD) begin
          if (!start_w) begin
            bresp <= lin_pkg::RESP_SLVERR;
          end
        end else begin
          bresp <= lin_pkg::RESP_SLVERR;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= lin_pkg::RESP_OKAY;
    end else if (rvalid) begin
      if (rready) begin
        rvalid <= 1'b0;
      end
    end else if (arvalid) begin
      rvalid <= 1'b1;
      rresp  <= lin_pkg::RESP_OKAY;
      rdata  <= 32'h00000000;
      if (araddr == lin_pkg::HOST_RESP) begin
        rdata <= {15'h0000, busy_w, resp_q};
      end else if (araddr == lin_pkg::HOST_TXCTL) begin
        rdata <= {30'h00000000, txctl_q};
      end else if (araddr == lin_pkg::HOST_RXSTAT) begin
        rdata <= {31'h00000000, s2_q[0]};
      end else if (araddr != lin_pkg::HOST_CMD) begin
        rresp <= lin_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Serial master, mode 0, MSB first
  logic [15:0] frame_w;
  logic [15:0] sr_q;
  logic [15:0] rx_q;
  logic [7:0]  div_q;
  logic [4:0]  edge_q;
  logic        tick;
  logic        sclk_q, cs_n_q;

  // Reads always carry a one in bit 8
  always_comb begin
    frame_w = wdata_q[15:0];
    if (wdata_q[lin_pkg::OP_HI:lin_pkg::OP_LO] != lin_pkg::OP_WRITE) begin
      frame_w[lin_pkg::PN_BIT] = 1'b1;
    end
  end

  assign tick = div_q == 8'(lin_pkg::SCLK_HALF - 1);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q   <= SP_IDLE;
      div_q  <= 8'h00;
      edge_q <= 5'h00;
      sr_q   <= 16'h0000;
      rx_q   <= 16'h0000;
      resp_q <= 16'h0000;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      div_q <= (st_q == SP_IDLE || tick) ? 8'h00 : div_q + 8'h01;
      case (st_q)
        SP_IDLE: begin
          if (start_w) begin
            sr_q   <= frame_w;
            cs_n_q <= 1'b0;
            edge_q <= 5'h00;
            st_q   <= SP_LEAD;
          end
        end
        SP_LEAD: if (tick) st_q <= SP_RUN;
        SP_RUN: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            edge_q <= edge_q + 5'h01;
            if (!sclk_q) begin
              rx_q <= {rx_q[14:0], s2_q[1]};
            end else begin
              sr_q <= {sr_q[14:0], 1'b0};
            end
            if (edge_q == 5'h1F) begin
              st_q <= SP_LAG;
            end
          end
        end
        SP_LAG: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            resp_q <= rx_q;
            st_q   <= SP_GAP;
          end
        end
        SP_GAP: if (tick) st_q <= SP_IDLE;
        default: st_q <= SP_IDLE;
      endcase
    end
  end

  assign link.sclk   = sclk_q;
  assign link.cs_n   = cs_n_q;
  assign link.mosi   = sr_q[15];
  assign link.txd    = txctl_q[0];
  assign link.txd_oe = txctl_q[1];

endmodule : lin_host_ctrl

// ---- tb/lin_link_properties.sv ----
// Concurrent checks on the link between the host end and the device end.
// Assumes the bench connects the link interface signals here by name.
module lin_link_properties (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic txd,
  input wire logic txd_oe,
  input wire logic txd_l,
  input wire logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Helper: serial clock rises seen in the current frame
  logic       sclk_q;
  logic [5:0] rises_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q  <= 1'b0;
      rises_q <= 6'h00;
    end else begin
      sclk_q  <= sclk;
      rises_q <= cs_n ? 6'h00 : rises_q + {5'h00, sclk & ~sclk_q};
    end
  end

  // ==========================================================
  // Assertions
  chk_frame_bits: assert property ($rose(cs_n) |-> rises_q == 6'h10)
    else $error("frame did not carry sixteen clocks");
  chk_lead_time: assert property ($fell(cs_n) |-> (!sclk) [*8])
    else $error("serial clock too soon after select");
  chk_sclk_half: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  chk_clock_still: assert property (cs_n |-> !sclk)
    else $error("serial clock moves outside a frame");
  chk_frame_gap: assert property ($rose(cs_n) |=> cs_n [*3])
    else $error("gap between frames too short");
  chk_frame_bound: assert property ($fell(cs_n) |-> ##[100:1000] $rose(cs_n))
    else $error("frame length out of range");
  chk_miso_quiet: assert property (cs_n && $past(cs_n) |-> !miso)
    else $error("reply line active while not selected");
  chk_txd_float: assert property (!txd_oe |-> txd_l)
    else $error("floating transmit input not recessive");
  chk_txd_follow: assert property (txd_oe |-> txd_l == txd)
    else $error("transmit input differs from host level");

  cover property ($fell(cs_n));
  cover property ($fell(rxd));
  cover property (txd_oe && !txd_l);
endmodule : lin_link_properties

// ---- tb/test_lin_transceiver_control.sv ----
// Bench for the LIN transceiver control: both ends joined by the link
// interface, orders given over AXI4-Lite. Assumes package and interface first.
module test_lin_transceiver_control;
  timeunit 1ns;
  timeprecision 1ps;
  // Short dominant timeout keeps the run brief
  localparam int TXDOM_SIM = 200;
  localparam int WAKE      = lin_pkg::WAKE_MIN_CYCLES;

  logic        core_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rate_sel;
  logic        ext_dom, supply_uv, over_temp, normal_state, lp_on, lp_off;
  logic        bus_drive_low, weak_pullup_en, hs_off, wake_event, wake_irq, supply_restart;
  logic        bus_level;
  int          mismatches = 0;
  int          checked = 0;
  int          n_irq = 0;
  int          n_rst = 0;
  int          n_evt = 0;
  logic [1:0]  rates [3] = '{lin_pkg::RATE_20K, lin_pkg::RATE_10K, lin_pkg::RATE_FAST};

  // Bus is dominant if either the device or another node pulls it
  assign bus_level = !bus_drive_low && !ext_dom;

  lin_link_if link ();
  lin_xcvr_dev #(.TXDOM_LIMIT(TXDOM_SIM)) u_lin_xcvr_dev (
    .core_clk(core_clk), .nrst(nrst), .link(link), .bus_level(bus_level),
    .supply_uv(supply_uv), .over_temp(over_temp), .normal_state(normal_state),
    .low_power_supply_on(lp_on), .low_power_supply_off(lp_off),
    .bus_drive_low(bus_drive_low), .weak_pullup_en(weak_pullup_en), .rate_sel(rate_sel),
    .hs_off(hs_off), .wake_event(wake_event), .wake_irq(wake_irq),
    .supply_restart(supply_restart));
  lin_host_ctrl u_lin_host_ctrl (
    .core_clk(core_clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(link));
  lin_link_properties u_lin_link_properties (
    .core_clk(core_clk), .nrst(nrst), .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso(link.miso), .txd(link.txd), .txd_oe(link.txd_oe),
    .txd_l(link.txd_l), .rxd(link.rxd));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (wake_irq === 1'b1) n_irq++;
    if (supply_restart === 1'b1) n_rst++;
    if (wake_event === 1'b1) n_evt++;
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  // Bit 8 is one for every operation but a write, zero parity on writes
  task automatic frame(input logic [1:0] op, input logic [7:0] d, output logic [15:0] rep);
    logic [1:0]  r;
    logic [31:0] v;
    axi_wr(lin_pkg::HOST_CMD, {16'h0000, op, lin_pkg::LIN_REG_ADDR, op != lin_pkg::OP_WRITE, d}, r);
    check("cmd resp", lin_pkg::RESP_OKAY, r);
    repeat (4) @(posedge core_clk);
    do axi_rd(lin_pkg::HOST_RESP, v, r); while (v[lin_pkg::HOST_BUSY_BIT] !== 1'b0);
    rep = v[15:0];
  endtask : frame

  task automatic drive_txd(input logic lvl, input logic oe);
    logic [1:0] r;
    axi_wr(lin_pkg::HOST_TXCTL, {30'h0, oe, lvl}, r);
    repeat (8) @(posedge core_clk);
  endtask : drive_txd

  task automatic pulse(input int n);
    ext_dom <= 1'b1;
    repeat (n) @(posedge core_clk);
    ext_dom <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask : pulse

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (80000) @(posedge core_clk);
    mismatches++;
    $display("watchdog expired");
    end_sim();
  end

  // ==========================================================
  // Tests
  initial begin
    logic [15:0] rep;
    logic [31:0] v;
    logic [1:0]  r;
    logic [7:0]  d;
    {nrst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {ext_dom, supply_uv, over_temp, normal_state, lp_on, lp_off} = '0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    axi_rd(8'h10, v, r);
    check("unmapped resp", lin_pkg::RESP_SLVERR, r);
    check("rxd inactive", 1'b1, link.rxd);
    frame(lin_pkg::OP_READBACK, 8'h00, rep);
    check("ctrl reset", lin_pkg::LIN_REG_RESET, rep[7:0]);
    $display("test reset done");

    normal_state <= 1'b1;
    drive_txd(1'b0, 1'b1);
    frame(lin_pkg::OP_WRITE, 8'h80, rep);
    frame(lin_pkg::OP_READBACK, 8'h00, rep);
    check("trx refused", 8'h00, rep[7:0]);
    drive_txd(1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      d = {2'b10, rates[i], 4'h0};
      frame(lin_pkg::OP_WRITE, d, rep);
      frame(lin_pkg::OP_READBACK, 8'h00, rep);
      check("ctrl readback", d, rep[7:0]);
      check("rate", rates[i], rate_sel);
    end
    check("active status", 1'b1, rep[15]);
    frame(lin_pkg::OP_RSVD, 8'h00, rep);
    frame(lin_pkg::OP_READBACK, 8'h00, rep);
    check("reserved ignored", d, rep[7:0]);
    $display("test modes done");

    drive_txd(1'b0, 1'b1);
    check("drive low", 1'b1, bus_drive_low);
    check("rxd dominant", 1'b0, link.rxd);
    supply_uv <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("uv blocks", 1'b0, bus_drive_low);
    supply_uv <= 1'b0;
    repeat (8) @(posedge core_clk);
    check("uv restored", 1'b1, bus_drive_low);
    over_temp <= 1'b1;
    ext_dom   <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("ot driver", 1'b0, bus_drive_low);
    check("ot receiver", 1'b1, link.rxd);
    check("ot high side", 1'b1, hs_off);
    over_temp <= 1'b0;
    ext_dom   <= 1'b0;
    normal_state <= 1'b0;
    repeat (8) @(posedge core_clk);
    check("not normal", 1'b0, bus_drive_low);
    normal_state <= 1'b1;
    repeat (TXDOM_SIM + 20) @(posedge core_clk);
    check("timeout", 1'b0, bus_drive_low);
    frame(lin_pkg::OP_FLAGS, 8'h00, rep);
    check("timeout flag", 1'b1, rep[3]);
    drive_txd(1'b1, 1'b1);
    check("released", 1'b1, link.rxd);
    frame(lin_pkg::OP_WRITE, 8'h00, rep);
    drive_txd(1'b0, 1'b1);
    check("disabled mode", 1'b0, bus_drive_low);
    drive_txd(1'b1, 1'b0);
    $display("test paths done");

    lp_on <= 1'b1;
    frame(lin_pkg::OP_WRITE, 8'h48, rep);
    check("weak pull-up", 1'b1, weak_pullup_en);
    pulse(WAKE - 500);
    check("short wake", 0, n_irq);
    pulse(WAKE + 100);
    check("wake irq", 1, n_irq);
    lp_on  <= 1'b0;
    lp_off <= 1'b1;
    pulse(WAKE + 100);
    check("wake restart", 1, n_rst);
    frame(lin_pkg::OP_WRITE, 8'h40, rep);
    pulse(WAKE + 100);
    check("wake disabled", 2, n_irq + n_rst);
    check("wake notice", 2, n_evt);
    $display("test wake done");
    end_sim();
  end
endmodule : test_lin_transceiver_control
